// *** hdl/compact_timer_pkg.sv ***
package compact_timer_pkg;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [4:0] OFF_CONTROL0 = 5'h00;
  localparam logic [4:0] OFF_CONTROL1 = 5'h04;
  localparam logic [4:0] OFF_COUNT_LOW = 5'h08;
  localparam logic [4:0] OFF_COUNT_HIGH = 5'h0c;
  localparam logic [4:0] OFF_COMPARE_A_LOW = 5'h10;
  localparam logic [4:0] OFF_COMPARE_A_HIGH = 5'h14;
  localparam logic [4:0] OFF_PERIOD_COMPARE = 5'h18;
  localparam logic [4:0] OFF_IRQ_FLAGS = 5'h1c;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int FLAG_A_POS = 0;
  localparam int FLAG_P_POS = 1;
  localparam logic [7:0] CONTROL0_RESET = 8'h00;
  localparam logic [7:0] CONTROL1_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'h00;
  localparam logic [15:0] COMPARE_A_RESET = 16'h0000;

  // ------------------------------------------------------------
  // clock select codes and prescaler masks
  // ------------------------------------------------------------
  localparam logic [2:0] CLK_HS_DIV4 = 3'h0;
  localparam logic [2:0] CLK_HS = 3'h1;
  localparam logic [2:0] CLK_HS_DIV16 = 3'h2;
  localparam logic [2:0] CLK_HS_DIV64 = 3'h3;
  localparam logic [2:0] CLK_SUB_A = 3'h4;
  localparam logic [2:0] CLK_SUB_B = 3'h5;
  localparam logic [2:0] CLK_EXT_RISE = 3'h6;
  localparam logic [2:0] CLK_EXT_FALL = 3'h7;
  localparam logic [5:0] DIV4_MASK = 6'h03;
  localparam logic [5:0] DIV16_MASK = 6'h0f;
  localparam logic [5:0] DIV64_MASK = 6'h3f;

  // ------------------------------------------------------------
  // mode and pin action codes, bus responses
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'h0,
    MODE_UNDEF = 2'h1,
    MODE_PWM = 2'h2,
    MODE_TIMER = 2'h3
  } mode_t;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic count_hold;
    logic [2:0] count_clock_select;
    logic timer_run;
    logic [2:0] period_compare_bits;
  } control0_t;

  typedef struct packed {
    mode_t operating_mode_select;
    logic [1:0] pin_action_select;
    logic output_start_level;
    logic output_invert;
    logic period_duty_swap;
    logic clear_source_select;
  } control1_t;

endpackage

// *** hdl/compact_timer_unit.sv ***
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - count-up counter, 10 or 16 bits wide, from a selectable clock source.
// - clock select: hs/4, hs, hs/16, hs/64, sub, sub, pin rise, pin fall.
// - hold bit freezes the counter; clearing it resumes from the kept value.
// - run rising clears counter and starts; run falling stops and keeps value.
// - run rising returns the output pin to its start level in compare output mode.
// - counter clears on overflow or selected comparator match; only a match raises a flag.
// - 10-bit: three period bits match counter bits 9..7; zero means 1024.
// - period value zero gives no period match; counter runs to overflow.
// - compare-A is counter width and compared with every counter bit.
// - mode field: 00 compare output, 10 pwm, 11 timer, 01 undefined.
// - timer mode drives the pin low and ignores pin action.
// - compare mode A match: keep, drive low, drive high or toggle pin.
// - pwm pin action: inactive, active, waveform; code 11 undefined.
// - second output pin always carries the inverse of the primary pin.
// - match output may lag one counter clock after start or value change.
// - counter readable and compare-A writable as low and high byte pairs.
// - 16-bit: period byte matches counter bits 15..8; zero means 65536.
// - outside pwm, clear select high clears on A match, low on period match or overflow.
// - start level sets compare-mode idle level and pwm active level.
// - invert bit inverts the primary pin except in timer mode.
module compact_timer_unit #(
  parameter int CNT_W = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_sub_clock,
  input wire logic i_external_count_clock_pin,
  input wire logic [4:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [4:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_timer_output_pin,
  output logic o_timer_output_pin_inverted,
  output logic [1:0] o_irq_flags
);

  localparam int PW = (CNT_W == 10) ? 3 : 8;
  localparam int LW = CNT_W - PW;
  localparam int HW = CNT_W - 8;

  if (CNT_W != 10 && CNT_W != 16) begin : g_bad_width
    $error("compact_timer_unit supports CNT_W of 10 or 16 only");
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  compact_timer_pkg::control0_t ctl0;
  compact_timer_pkg::control1_t ctl1;
  logic [7:0] period_byte;
  logic [CNT_W-1:0] compare_a;
  logic [CNT_W-1:0] count;
  logic [7:0] cmpa_buf;
  logic [7:0] cnt_buf;
  logic flag_a;
  logic flag_p;
  logic run_q;
  logic [5:0] prescale;
  logic sub_q;
  logic ext_q;
  logic out_raw;

  // ------------------------------------------------------------
  // bus write channel
  // ------------------------------------------------------------
  logic aw_full, w_full;
  logic [4:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic aw_take, w_take, do_write;
  logic next_aw_full, next_w_full, next_bvalid;
  logic wr_hit;

  assign aw_take = i_awvalid & o_awready;
  assign w_take = i_wvalid & o_wready;
  assign do_write = aw_full & w_full & ~o_bvalid;
  assign next_aw_full = (aw_full | aw_take) & ~do_write;
  assign next_w_full = (w_full | w_take) & ~do_write;
  assign next_bvalid = (o_bvalid & ~i_bready) | do_write;
  assign wr_hit = do_write & wstrb0_q;

  logic wr_ok;
  always_comb begin
    case (awaddr_q)
      compact_timer_pkg::OFF_CONTROL0,
      compact_timer_pkg::OFF_CONTROL1,
      compact_timer_pkg::OFF_COUNT_LOW,
      compact_timer_pkg::OFF_COUNT_HIGH,
      compact_timer_pkg::OFF_COMPARE_A_LOW,
      compact_timer_pkg::OFF_COMPARE_A_HIGH,
      compact_timer_pkg::OFF_IRQ_FLAGS: wr_ok = 1'b1;
      compact_timer_pkg::OFF_PERIOD_COMPARE: wr_ok = (CNT_W == 16);
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awaddr_q <= 5'h00;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= compact_timer_pkg::RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      o_bvalid <= next_bvalid;
      o_awready <= ~next_aw_full & ~next_bvalid;
      o_wready <= ~next_w_full & ~next_bvalid;
      if (aw_take) begin
        awaddr_q <= {i_awaddr[4:2], 2'b00};
      end
      if (w_take) begin
        wdata_q <= i_wdata[7:0];
        wstrb0_q <= i_wstrb[0];
      end
      if (do_write) begin
        o_bresp <= wr_ok ? compact_timer_pkg::RESP_OKAY
                         : compact_timer_pkg::RESP_SLVERR;
      end
    end
  end

  logic wr_c0, wr_c1, wr_al, wr_ah, wr_rp, wr_fl;
  assign wr_c0 = wr_hit & (awaddr_q == compact_timer_pkg::OFF_CONTROL0);
  assign wr_c1 = wr_hit & (awaddr_q == compact_timer_pkg::OFF_CONTROL1);
  assign wr_al = wr_hit & (awaddr_q == compact_timer_pkg::OFF_COMPARE_A_LOW);
  assign wr_ah = wr_hit & (awaddr_q == compact_timer_pkg::OFF_COMPARE_A_HIGH);
  assign wr_rp = wr_hit & (awaddr_q == compact_timer_pkg::OFF_PERIOD_COMPARE)
               & (CNT_W == 16);
  assign wr_fl = wr_hit & (awaddr_q == compact_timer_pkg::OFF_IRQ_FLAGS);

  // ------------------------------------------------------------
  // bus read channel
  // ------------------------------------------------------------
  logic ar_take, next_rvalid;
  logic [4:0] rd_addr;
  logic [7:0] rd_byte;
  logic rd_ok;

  assign ar_take = i_arvalid & o_arready;
  assign next_rvalid = ar_take | (o_rvalid & ~i_rready);
  assign rd_addr = {i_araddr[4:2], 2'b00};

  always_comb begin
    rd_byte = 8'h00;
    rd_ok = 1'b1;
    case (rd_addr)
      compact_timer_pkg::OFF_CONTROL0: begin
        rd_byte = ctl0;
        if (CNT_W == 16) begin
          rd_byte[2:0] = 3'h0;
        end
      end
      compact_timer_pkg::OFF_CONTROL1: rd_byte = ctl1;
      compact_timer_pkg::OFF_COUNT_LOW: rd_byte = cnt_buf;
      compact_timer_pkg::OFF_COUNT_HIGH:
        rd_byte[HW-1:0] = count[CNT_W-1:8];
      compact_timer_pkg::OFF_COMPARE_A_LOW: rd_byte = cmpa_buf;
      compact_timer_pkg::OFF_COMPARE_A_HIGH:
        rd_byte[HW-1:0] = compare_a[CNT_W-1:8];
      compact_timer_pkg::OFF_PERIOD_COMPARE: begin
        rd_byte = (CNT_W == 16) ? period_byte : 8'h00;
        rd_ok = (CNT_W == 16);
      end
      compact_timer_pkg::OFF_IRQ_FLAGS: rd_byte = {6'h00, flag_p, flag_a};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= compact_timer_pkg::RESP_OKAY;
    end else begin
      o_rvalid <= next_rvalid;
      o_arready <= ~next_rvalid;
      if (ar_take) begin
        o_rdata <= {24'h000000, rd_byte};
        o_rresp <= rd_ok ? compact_timer_pkg::RESP_OKAY
                         : compact_timer_pkg::RESP_SLVERR;
      end
    end
  end

  logic rd_dh, rd_ah;
  assign rd_dh = ar_take & (rd_addr == compact_timer_pkg::OFF_COUNT_HIGH);
  assign rd_ah = ar_take & (rd_addr == compact_timer_pkg::OFF_COMPARE_A_HIGH);

  // ------------------------------------------------------------
  // control registers and byte buffers
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctl0 <= compact_timer_pkg::CONTROL0_RESET;
      ctl1 <= compact_timer_pkg::CONTROL1_RESET;
      period_byte <= compact_timer_pkg::PERIOD_RESET;
      compare_a <= compact_timer_pkg::COMPARE_A_RESET[CNT_W-1:0];
      cmpa_buf <= 8'h00;
      cnt_buf <= 8'h00;
    end else begin
      if (wr_c0) begin
        ctl0 <= wdata_q;
      end
      if (wr_c1) begin
        ctl1 <= wdata_q;
      end
      if (wr_rp) begin
        period_byte <= wdata_q;
      end
      if (wr_al) begin
        cmpa_buf <= wdata_q;
      end else if (wr_ah) begin
        compare_a <= {wdata_q[HW-1:0], cmpa_buf};
      end else if (rd_ah) begin
        cmpa_buf <= compare_a[7:0];
      end
      if (rd_dh) begin
        cnt_buf <= count[7:0];
      end
    end
  end

  // ------------------------------------------------------------
  // counter clock selection
  // ------------------------------------------------------------
  logic tick_src;
  always_comb begin
    case (ctl0.count_clock_select)
      compact_timer_pkg::CLK_HS_DIV4:
        tick_src = (prescale[1:0] == compact_timer_pkg::DIV4_MASK[1:0]);
      compact_timer_pkg::CLK_HS: tick_src = 1'b1;
      compact_timer_pkg::CLK_HS_DIV16:
        tick_src = (prescale[3:0] == compact_timer_pkg::DIV16_MASK[3:0]);
      compact_timer_pkg::CLK_HS_DIV64:
        tick_src = (prescale == compact_timer_pkg::DIV64_MASK);
      compact_timer_pkg::CLK_SUB_A,
      compact_timer_pkg::CLK_SUB_B: tick_src = i_sub_clock & ~sub_q;
      compact_timer_pkg::CLK_EXT_RISE:
        tick_src = i_external_count_clock_pin & ~ext_q;
      compact_timer_pkg::CLK_EXT_FALL:
        tick_src = ~i_external_count_clock_pin & ext_q;
      default: tick_src = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prescale <= 6'h00;
      sub_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      prescale <= prescale + 6'h01;
      sub_q <= i_sub_clock;
      ext_q <= i_external_count_clock_pin;
    end
  end

  // ------------------------------------------------------------
  // counter and comparators
  // ------------------------------------------------------------
  logic [PW-1:0] period_val;
  logic [CNT_W-1:0] count_inc;
  logic run_rise, tick, a_hit, p_hit, clear_now, is_pwm;

  assign period_val = (CNT_W == 10) ? PW'(ctl0.period_compare_bits)
                                    : PW'(period_byte);
  assign is_pwm = (ctl1.operating_mode_select == compact_timer_pkg::MODE_PWM);
  assign run_rise = ctl0.timer_run & ~run_q;
  assign tick = tick_src & ctl0.timer_run & ~ctl0.count_hold
              & ~run_rise;
  assign count_inc = count + CNT_W'(1);
  assign a_hit = (compare_a != '0) & (count_inc == compare_a);
  // period match when the top bits reach the code; zero never matches
  assign p_hit = (period_val != '0)
               & (count_inc[CNT_W-1 -: PW] == period_val)
               & (count_inc[LW-1:0] == '0);
  assign clear_now = is_pwm ? (ctl1.period_duty_swap ? a_hit : p_hit)
                   : (ctl1.clear_source_select ? a_hit : p_hit);

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      run_q <= 1'b0;
      count <= '0;
    end else begin
      run_q <= ctl0.timer_run;
      if (run_rise) begin
        count <= '0;
      end else if (tick) begin
        // overflow wraps to zero by itself
        count <= clear_now ? '0 : count_inc;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt request flags
  // ------------------------------------------------------------
  logic set_a, set_p;
  assign set_a = tick & a_hit;
  assign set_p = tick & p_hit & ~(ctl1.clear_source_select & ~is_pwm);

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      flag_a <= 1'b0;
      flag_p <= 1'b0;
      o_irq_flags <= 2'h0;
    end else begin
      // a new match wins over a write-one clear in the same cycle
      flag_a <= set_a | (flag_a & ~(wr_fl
              & wdata_q[compact_timer_pkg::FLAG_A_POS]));
      flag_p <= set_p | (flag_p & ~(wr_fl
              & wdata_q[compact_timer_pkg::FLAG_P_POS]));
      o_irq_flags <= {set_p | flag_p, set_a | flag_a};
    end
  end

  // ------------------------------------------------------------
  // output pin logic
  // ------------------------------------------------------------
  logic pwm_on, pwm_level, pin_level;
  assign pwm_on = ctl1.period_duty_swap
                ? (count[CNT_W-1 -: PW] < period_val)
                : (count < compare_a);
  always_comb begin
    case (ctl1.pin_action_select)
      compact_timer_pkg::ACT_LOW: pwm_level = ctl1.output_start_level;
      compact_timer_pkg::ACT_HIGH:
        pwm_level = pwm_on ? ctl1.output_start_level
                           : ~ctl1.output_start_level;
      default: pwm_level = ~ctl1.output_start_level;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      out_raw <= 1'b0;
    end else if (run_rise) begin
      out_raw <= ctl1.output_start_level;
    end else if (ctl1.operating_mode_select == compact_timer_pkg::MODE_COMPARE
                 && set_a) begin
      case (ctl1.pin_action_select)
        compact_timer_pkg::ACT_LOW: out_raw <= 1'b0;
        compact_timer_pkg::ACT_HIGH: out_raw <= 1'b1;
        compact_timer_pkg::ACT_TOGGLE: out_raw <= ~out_raw;
        default: out_raw <= out_raw;
      endcase
    end
  end

  always_comb begin
    case (ctl1.operating_mode_select)
      compact_timer_pkg::MODE_COMPARE: pin_level = out_raw;
      compact_timer_pkg::MODE_PWM: pin_level = pwm_level;
      default: pin_level = 1'b0;
    endcase
  end

  // invert has no effect in timer mode
  logic pin_flip;
  assign pin_flip = ctl1.output_invert
    & (ctl1.operating_mode_select != compact_timer_pkg::MODE_TIMER);

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_timer_output_pin <= 1'b0;
      o_timer_output_pin_inverted <= 1'b1;
    end else begin
      o_timer_output_pin <= pin_level ^ pin_flip;
      o_timer_output_pin_inverted <= ~(pin_level ^ pin_flip);
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  a_run_clears_count: assert property (run_rise |=> count == '0)
    else $error("count not cleared on run rise");
  a_hold_keeps_count: assert property (ctl0.count_hold && !run_rise
    |=> $stable(count))
    else $error("count moved while held");
  a_stop_keeps_count: assert property (!ctl0.timer_run |=> $stable(count))
    else $error("count moved while stopped");
  a_start_level: assert property (run_rise && ctl1.operating_mode_select
    == compact_timer_pkg::MODE_COMPARE |=> ##1 o_timer_output_pin
    == (ctl1.output_start_level ^ ctl1.output_invert))
    else $error("pin not at start level after run rise");
  a_pins_inverse: assert property (o_timer_output_pin
    != o_timer_output_pin_inverted)
    else $error("pins not inverse of each other");
  a_clear_on_match: assert property (tick && clear_now && !run_rise
    |=> count == '0)
    else $error("counter not cleared on match");
  a_flag_a_sets: assert property (set_a |=> flag_a ##1 o_irq_flags[0])
    else $error("compare flag not raised");
  a_no_p_flag: assert property (tick && ctl1.clear_source_select && !is_pwm
    && !flag_p && !(flag_p && wr_fl) |=> !flag_p)
    else $error("period flag set with clear on A");
  a_period_zero: assert property (period_val == '0 |-> !p_hit)
    else $error("period match with zero code");
  a_write_answer: assert property (do_write |=> o_bvalid)
    else $error("write answer missing");

  c_compare_match: cover property (set_a && !is_pwm);
  c_period_match: cover property (set_p);
  c_pwm_run: cover property (is_pwm && ctl0.timer_run ##1 tick);
  c_overflow: cover property (tick && count_inc == '0);

endmodule

`default_nettype wire

// *** tb/compact_timer_module_test.sv ***
`timescale 1ns/100ps
`default_nettype none

module compact_timer_module_test;
  logic i_sys_clk = 0, i_resetn = 0, sub = 0, en = 0, slow = 0, ext;
  logic [4:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid, pin, pin_n;
  logic [1:0] bresp, rresp, flags, r;
  logic [15:0] v;
  logic [7:0] b;
  int fail_count = 0, checks = 0, cyc = 0, n_a, t0, t1, k;
  int divs[8] = '{4, 1, 16, 64, 16, 16, 10, 20};
  logic [7:0] tab[7] = '{8'h19, 8'h21, 8'h09, 8'h25, 8'h89, 8'h99, 8'hc1};
  logic [1:0] ex[7] = '{2'h2, 2'h1, 2'h3, 2'h2, 2'h0, 2'h3, 2'h0};

  compact_timer_unit #(.CNT_W(16)) dut_u (.i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn), .i_sub_clock(sub),
    .i_external_count_clock_pin(ext), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .o_timer_output_pin(pin),
    .o_timer_output_pin_inverted(pin_n), .o_irq_flags(flags));

  count_pin_source ext_u (.i_sys_clk(i_sys_clk), .i_enable(en),
    .i_slow(slow), .o_pin(ext));

  initial forever #20 i_sys_clk = ~i_sys_clk;

  // sub clock rises once every 16 system clocks
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc % 8 == 7) sub <= ~sub;
  end

  always @(negedge i_sys_clk) begin
    if (i_resetn) chk("inv", 16'(!pin), 16'(pin_n));
  end

  // ------------------------------------------------------------
  // bus and check tasks
  // ------------------------------------------------------------
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic tick(int c);
    repeat (c) @(posedge i_sys_clk);
  endtask

  task automatic test_done;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic hang;
    fail_count++;
    $display("CHECK FAILED wait expected done seen timeout");
    test_done;
  endtask

  task automatic wr(logic [4:0] a, logic [7:0] d);
    int n;
    @(posedge i_sys_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_sys_clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    r = bresp;
    if (n == 50) hang;
  endtask

  task automatic rd(logic [4:0] a, output logic [7:0] d);
    int n;
    @(posedge i_sys_clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_sys_clk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    rready <= 0;
    d = rdata[7:0];
    r = rresp;
    if (n == 50) hang;
  endtask

  // high byte first: that read latches the low byte
  task automatic rdcnt;
    logic [7:0] h;
    rd(compact_timer_pkg::OFF_COUNT_HIGH, h);
    rd(compact_timer_pkg::OFF_COUNT_LOW, b);
    v = {h, b};
  endtask

  task automatic wpin(output int t);
    logic p;
    int n;
    p = pin;
    for (n = 0; n < 300 && pin === p; n++) @(posedge i_sys_clk);
    if (n == 300) hang;
    t = cyc;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(27));
    n_a = 20 + $urandom % 61;
    tick(2);
    i_resetn <= 1;
    for (k = 0; k < 8; k++) begin
      rd(5'(4 * k), b);
      chk("reset", 0, 16'(b));
    end
    // low address bits are ignored: this reads control0
    rd(5'h02, b);
    chk("alias_resp", 16'(compact_timer_pkg::RESP_OKAY), 16'(r));
    chk("alias_data", 0, 16'(b));
    $display("test registers finished");
    wr(compact_timer_pkg::OFF_CONTROL0, 8'h18);
    tick(100);
    wr(compact_timer_pkg::OFF_CONTROL0, 8'h98);
    rdcnt;
    t0 = v;
    tick(50);
    rdcnt;
    chk("hold", 16'(t0), v);
    wr(compact_timer_pkg::OFF_CONTROL0, 8'h18);
    tick(20);
    rdcnt;
    chk("resume", 1, 16'(v > t0 && v < t0 + 60));
    wr(compact_timer_pkg::OFF_CONTROL0, 8'h10);
    $display("test hold finished");
    for (k = 0; k < 8; k++) begin
      en <= k > 5;
      slow <= k == 7;
      wr(compact_timer_pkg::OFF_CONTROL0, {1'b0, 3'(k), 4'h8});
      t0 = cyc;
      tick(640);
      wr(compact_timer_pkg::OFF_CONTROL0, {1'b0, 3'(k), 4'h0});
      t1 = (cyc - t0) / divs[k];
      rdcnt;
      chk("clk_sel", 1, 16'(v + 2 >= t1 && v <= t1 + 2));
    end
    $display("test clock select finished");
    wr(compact_timer_pkg::OFF_CONTROL1, 8'h31);
    wr(compact_timer_pkg::OFF_COMPARE_A_LOW, 8'(n_a));
    wr(compact_timer_pkg::OFF_COMPARE_A_HIGH, 8'h00);
    wr(compact_timer_pkg::OFF_CONTROL0, 8'h18);
    wpin(t0);
    wpin(t1);
    chk("toggle", 16'(n_a), 16'(t1 - t0));
    chk("flag_a", 1, 16'(flags[0]));
    rd(compact_timer_pkg::OFF_COMPARE_A_HIGH, b);
    rd(compact_timer_pkg::OFF_COMPARE_A_LOW, b);
    chk("cmp_a", 16'(n_a), 16'(b));
    $display("test toggle finished");
    for (k = 0; k < 7; k++) begin
      wr(compact_timer_pkg::OFF_CONTROL0, 8'h10);
      wr(compact_timer_pkg::OFF_CONTROL1, tab[k]);
      wr(compact_timer_pkg::OFF_CONTROL0, 8'h18);
      tick(4);
      chk("pin_start", 16'(ex[k][1]), 16'(pin));
      tick(2 * n_a);
      chk("pin_match", 16'(ex[k][0]), 16'(pin));
    end
    $display("test pin actions finished");
    wr(compact_timer_pkg::OFF_CONTROL0, 8'h10);
    wr(compact_timer_pkg::OFF_CONTROL1, 8'h00);
    wr(compact_timer_pkg::OFF_PERIOD_COMPARE, 8'h01);
    chk("bresp", 16'(compact_timer_pkg::RESP_OKAY), 16'(r));
    wr(compact_timer_pkg::OFF_IRQ_FLAGS, 8'h03);
    wr(compact_timer_pkg::OFF_CONTROL0, 8'h18);
    t0 = cyc;
    for (k = 0; k < 400 && flags[1] !== 1; k++) tick(1);
    chk("period", 1, 16'(cyc - t0 > 252 && cyc - t0 < 260));
    wr(compact_timer_pkg::OFF_IRQ_FLAGS, 8'h02);
    rd(compact_timer_pkg::OFF_IRQ_FLAGS, b);
    chk("flag_p_clr", 0, 16'(b[1]));
    $display("test period finished");
    test_done;
  end
endmodule

`default_nettype wire

// *** tb/count_pin_source.sv ***
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// far side: external count pin driver, fast or slow
// ------------------------------------------------------------
module count_pin_source (
  input wire logic i_sys_clk,
  input wire logic i_enable,
  input wire logic i_slow,
  output logic o_pin
);
  int phase = 0;

  // pin rests low outside bursts and is only ever driven here
  always @(posedge i_sys_clk) begin
    if (!i_enable) begin
      phase <= 0;
      o_pin <= 1'b0;
    end else if (phase >= (i_slow ? 9 : 4)) begin
      phase <= 0;
      o_pin <= ~o_pin;
    end else begin
      phase <= phase + 1;
    end
  end
endmodule

`default_nettype wire
